// [rtl/mgx_cfg_regs.svh]
`ifndef MGX_CFG_REGS_SVH
`define MGX_CFG_REGS_SVH

// Instruction codes
`define MGX_OP_READ_EE 8'h25
`define MGX_OP_WRITE 8'h31
`define MGX_OP_MASKED 8'h32
`define MGX_OP_READ_REG 8'h33
`define MGX_OP_READ_ALL 8'h34
`define MGX_OP_LOAD 8'h35

// Register space
`define MGX_NUM_REGS 102
`define MGX_LAST_ADDR 8'h65
`define MGX_FIRST_ADDR 8'h00
`define MGX_SLAVE_LO 8'h0C
`define MGX_SLAVE_HI 8'h13
`define MGX_PROT_LO 8'h60
`define MGX_PROT_HI 8'h65

`endif

// [rtl/mgx_pkg.sv]
`include "mgx_cfg_regs.svh"

package mgx_pkg;

    typedef enum logic [2:0] {
        ST_IDLE, ST_CODE, ST_ADDR, ST_WDATA, ST_WMASK, ST_WMDATA, ST_LOAD,
        ST_SKIP
    } mgx_state_t;

    typedef enum logic [1:0] {
        OP_WRITE, OP_MASKED, OP_READ_EE, OP_READ_REG
    } mgx_op_t;

    typedef enum logic [1:0] {
        SRC_NONE, SRC_EE, SRC_REG
    } mgx_src_t;

    typedef logic [`MGX_NUM_REGS-1:0][7:0] mgx_bytes_t;

    typedef struct packed {
        mgx_state_t state;
        mgx_op_t op;
        mgx_src_t rd_src;
        logic [7:0] addr;
        logic [7:0] mask;
        logic [7:0] tx_data;
        logic tx_valid;
        logic load;
    } mgx_cmd_state_t;

    typedef struct packed {
        mgx_bytes_t master;
        mgx_bytes_t slave;
        logic upd;
        logic [7:0] upd_addr;
    } mgx_reg_state_t;

    function automatic logic is_slave(input logic [7:0] a);
        return a >= `MGX_SLAVE_LO && a <= `MGX_SLAVE_HI;
    endfunction

    function automatic logic is_prot(input logic [7:0] a);
        return a >= `MGX_PROT_LO && a <= `MGX_PROT_HI;
    endfunction

endpackage

// [rtl/mgx_cfg_if.sv]
`timescale 1ns/1ps

interface mgx_cfg_if;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] wr_mask;
    logic load;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;

    modport cmd (
        output wr_en, wr_addr, wr_data, wr_mask, load, rd_addr,
        input rd_data
    );
    modport regs (
        input wr_en, wr_addr, wr_data, wr_mask, load, rd_addr,
        output rd_data
    );
endinterface

// [rtl/mgx_cfg_regfile.sv]
`timescale 1ns/1ps
`include "mgx_cfg_regs.svh"

module mgx_cfg_regfile (
    // Clock and synchronised reset
    input wire logic clk,
    input wire logic rst_n,
    // Command side
    mgx_cfg_if.regs cfg,
    // Operational values
    output mgx_pkg::mgx_bytes_t cfg_live,
    output logic cfg_upd,
    output logic [7:0] cfg_upd_addr
);
    mgx_pkg::mgx_reg_state_t s;
    mgx_pkg::mgx_reg_state_t next_s;
    logic wr_ok;

    assign wr_ok = cfg.wr_en && cfg.wr_addr <= `MGX_LAST_ADDR
                   && !mgx_pkg::is_prot(cfg.wr_addr);

    always_comb begin
        next_s = s;
        next_s.upd = 1'b0;
        if (wr_ok) begin
            // Mask bit 1 keeps the old bit, 0 takes the data bit
            next_s.master[cfg.wr_addr] = (s.master[cfg.wr_addr] & cfg.wr_mask)
                | (cfg.wr_data & ~cfg.wr_mask);
            if (!mgx_pkg::is_slave(cfg.wr_addr)) begin
                next_s.upd = 1'b1;
                next_s.upd_addr = cfg.wr_addr;
            end
        end
        if (cfg.load) begin
            for (int i = 0; i < `MGX_NUM_REGS; i++) begin
                if (mgx_pkg::is_slave(8'(i))) begin
                    next_s.slave[i] = s.master[i];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Paired registers run from the slave copy, the rest at once
    for (genvar g = 0; g < `MGX_NUM_REGS; g++) begin : g_live
        assign cfg_live[g] = mgx_pkg::is_slave(8'(g)) ? s.slave[g]
                                                      : s.master[g];
    end

    assign cfg.rd_data = (cfg.rd_addr <= `MGX_LAST_ADDR)
                         ? s.master[cfg.rd_addr] : 8'h00;
    assign cfg_upd = s.upd;
    assign cfg_upd_addr = s.upd_addr;

    chk_slave_hold: assert property (@(posedge clk) disable iff (!rst_n)
        cfg.wr_en && !cfg.load && mgx_pkg::is_slave(cfg.wr_addr)
        |=> cfg_live[$past(cfg.wr_addr)] == $past(cfg_live[cfg.wr_addr]))
        else $error("Slave copy changed by a write");

    chk_mask_merge: assert property (@(posedge clk) disable iff (!rst_n)
        wr_ok |=> s.master[$past(cfg.wr_addr)] ==
        (($past(s.master[cfg.wr_addr]) & $past(cfg.wr_mask))
         | ($past(cfg.wr_data) & ~$past(cfg.wr_mask))))
        else $error("Masked merge wrong");

    chk_prot_keep: assert property (@(posedge clk) disable iff (!rst_n)
        cfg.wr_en && mgx_pkg::is_prot(cfg.wr_addr)
        |=> s.master[$past(cfg.wr_addr)] == $past(s.master[cfg.wr_addr]))
        else $error("Protected register was written");

    chk_upd_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        wr_ok && !mgx_pkg::is_slave(cfg.wr_addr)
        |=> (cfg_upd && cfg_upd_addr == $past(cfg.wr_addr))
            ##1 (!cfg_upd
                 || $past(wr_ok && !mgx_pkg::is_slave(cfg.wr_addr))))
        else $error("Master-only update pulse missing");

endmodule // mgx_cfg_regfile

// [rtl/mgx_cfg_access.sv]
`timescale 1ns/1ps
`include "mgx_cfg_regs.svh"

module mgx_cfg_access (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Byte link from the bus slave front end
    input wire logic xfer_start,
    input wire logic xfer_read,
    input wire logic xfer_stop,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic tx_req,
    output logic tx_valid,
    output logic [7:0] tx_data,
    // Stored image read port
    output logic [7:0] ee_addr,
    input wire logic [7:0] ee_data,
    // Configuration outputs
    output mgx_pkg::mgx_bytes_t cfg_live,
    output logic cfg_upd,
    output logic [7:0] cfg_upd_addr,
    output logic load_done
);
    logic rst_meta_n;
    logic rst_sync_n;
    mgx_pkg::mgx_cmd_state_t s;
    mgx_pkg::mgx_cmd_state_t next_s;
    mgx_cfg_if cfg ();

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    always_comb begin
        next_s = s;
        next_s.tx_valid = 1'b0;
        next_s.load = 1'b0;
        if (xfer_start) begin
            // Read transactions keep the source set up by the last write
            next_s.state = xfer_read ? mgx_pkg::ST_IDLE : mgx_pkg::ST_CODE;
        end else if (xfer_stop) begin
            if (s.state == mgx_pkg::ST_LOAD) begin
                next_s.load = 1'b1;
            end
            next_s.state = mgx_pkg::ST_IDLE;
        end else if (rx_valid) begin
            case (s.state)
                mgx_pkg::ST_CODE: begin
                    next_s.rd_src = mgx_pkg::SRC_NONE;
                    next_s.state = mgx_pkg::ST_ADDR;
                    case (rx_data)
                        `MGX_OP_READ_EE: next_s.op = mgx_pkg::OP_READ_EE;
                        `MGX_OP_WRITE: next_s.op = mgx_pkg::OP_WRITE;
                        `MGX_OP_MASKED: next_s.op = mgx_pkg::OP_MASKED;
                        `MGX_OP_READ_REG: next_s.op = mgx_pkg::OP_READ_REG;
                        `MGX_OP_READ_ALL: begin
                            next_s.addr = `MGX_FIRST_ADDR;
                            next_s.rd_src = mgx_pkg::SRC_REG;
                            next_s.state = mgx_pkg::ST_IDLE;
                        end
                        `MGX_OP_LOAD: next_s.state = mgx_pkg::ST_LOAD;
                        default: next_s.state = mgx_pkg::ST_SKIP;
                    endcase
                end
                mgx_pkg::ST_ADDR: begin
                    next_s.addr = rx_data;
                    case (s.op)
                        mgx_pkg::OP_WRITE: next_s.state = mgx_pkg::ST_WDATA;
                        mgx_pkg::OP_MASKED: next_s.state = mgx_pkg::ST_WMASK;
                        mgx_pkg::OP_READ_EE: begin
                            next_s.rd_src = mgx_pkg::SRC_EE;
                            next_s.state = mgx_pkg::ST_IDLE;
                        end
                        default: begin
                            next_s.rd_src = mgx_pkg::SRC_REG;
                            next_s.state = mgx_pkg::ST_IDLE;
                        end
                    endcase
                end
                mgx_pkg::ST_WDATA: next_s.addr = s.addr + 8'h01;
                mgx_pkg::ST_WMASK: begin
                    next_s.mask = rx_data;
                    next_s.state = mgx_pkg::ST_WMDATA;
                end
                mgx_pkg::ST_WMDATA: begin
                    next_s.addr = s.addr + 8'h01;
                    next_s.state = mgx_pkg::ST_WMASK;
                end
                mgx_pkg::ST_LOAD: next_s.state = mgx_pkg::ST_SKIP;
                default: next_s.state = s.state;
            endcase
        end else if (tx_req) begin
            next_s.tx_valid = 1'b1;
            case (s.rd_src)
                mgx_pkg::SRC_EE: next_s.tx_data = ee_data;
                mgx_pkg::SRC_REG: next_s.tx_data = cfg.rd_data;
                default: next_s.tx_data = 8'h00;
            endcase
            if (s.rd_src != mgx_pkg::SRC_NONE) begin
                next_s.addr = s.addr + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Write strobe is taken in the same cycle as the data byte
    assign cfg.wr_en = rx_valid && !xfer_start && !xfer_stop
                       && (s.state == mgx_pkg::ST_WDATA
                           || s.state == mgx_pkg::ST_WMDATA);
    assign cfg.wr_addr = s.addr;
    assign cfg.wr_data = rx_data;
    assign cfg.wr_mask = (s.state == mgx_pkg::ST_WMDATA) ? s.mask : 8'h00;
    assign cfg.load = s.load;
    assign cfg.rd_addr = s.addr;

    mgx_cfg_regfile u_regfile (
        .clk(clk),
        .rst_n(rst_sync_n),
        .cfg(cfg),
        .cfg_live(cfg_live),
        .cfg_upd(cfg_upd),
        .cfg_upd_addr(cfg_upd_addr)
    );

    assign tx_valid = s.tx_valid;
    assign tx_data = s.tx_data;
    assign ee_addr = s.addr;
    assign load_done = s.load;

    chk_read_advance: assert property (@(posedge clk) disable iff (!rst_sync_n)
        tx_req && !xfer_start && !xfer_stop && !rx_valid
        && s.rd_src != mgx_pkg::SRC_NONE
        |=> s.addr == $past(s.addr) + 8'h01 && tx_valid)
        else $error("Read address did not advance");

    chk_ee_source: assert property (@(posedge clk) disable iff (!rst_sync_n)
        tx_req && !xfer_start && !xfer_stop && !rx_valid
        && s.rd_src == mgx_pkg::SRC_EE |=> tx_data == $past(ee_data))
        else $error("Stored image byte not returned");

    chk_readall_zero: assert property (@(posedge clk) disable iff (!rst_sync_n)
        rx_valid && !xfer_start && !xfer_stop && s.state == mgx_pkg::ST_CODE
        && rx_data == `MGX_OP_READ_ALL
        |=> s.addr == `MGX_FIRST_ADDR && s.rd_src == mgx_pkg::SRC_REG)
        else $error("Read-all did not start at zero");

    chk_load_on_stop: assert property (@(posedge clk) disable iff (!rst_sync_n)
        xfer_stop && !xfer_start && s.state == mgx_pkg::ST_LOAD
        |=> load_done ##1 !load_done)
        else $error("Load not issued once at stop");

    chk_load_cause: assert property (@(posedge clk) disable iff (!rst_sync_n)
        load_done |-> $past(xfer_stop) && $past(s.state) == mgx_pkg::ST_LOAD)
        else $error("Load without a bare load instruction");

    chk_stop_idle: assert property (@(posedge clk) disable iff (!rst_sync_n)
        xfer_stop && !xfer_start |=> s.state == mgx_pkg::ST_IDLE)
        else $error("Stop did not end the transaction");

    chk_half_pair: assert property (@(posedge clk) disable iff (!rst_sync_n)
        s.state == mgx_pkg::ST_WMASK |-> !cfg.wr_en)
        else $error("Mask byte alone caused a write");

    chk_plain_write: assert property (@(posedge clk) disable iff (!rst_sync_n)
        rx_valid && !xfer_start && !xfer_stop && s.state == mgx_pkg::ST_WDATA
        |-> cfg.wr_en && cfg.wr_mask == 8'h00
        ##1 s.addr == $past(s.addr) + 8'h01)
        else $error("Plain write byte not stored");

endmodule // mgx_cfg_access

// [tb/mgx_link_master.sv]
`timescale 1ns/1ps

module mgx_link_master (
    // Clock
    input wire logic clk,
    // Link towards the block
    output logic xfer_start,
    output logic xfer_read,
    output logic xfer_stop,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic tx_req,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data
);
    initial begin
        xfer_start = 1'b0;
        xfer_read = 1'b0;
        xfer_stop = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_req = 1'b0;
    end

    // Start or repeated start, address matched; write bit low for writes
    task automatic bus_start(input logic rd);
        @(posedge clk);
        xfer_start <= 1'b1;
        xfer_read <= rd;
        @(posedge clk);
        xfer_start <= 1'b0;
    endtask

    task automatic put(input logic [7:0] b);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_data <= b;
        @(posedge clk);
        rx_valid <= 1'b0;
        // Released byte lane shows no stale value
        rx_data <= ~b;
    endtask

    // Stop pulse, one clock wide, after the last byte
    task automatic bus_stop();
        @(posedge clk);
        xfer_stop <= 1'b1;
        @(posedge clk);
        xfer_stop <= 1'b0;
    endtask

    task automatic get(output logic [7:0] b);
        @(posedge clk);
        tx_req <= 1'b1;
        @(posedge clk);
        tx_req <= 1'b0;
        #1;
        b = (tx_valid === 1'b1) ? tx_data : 8'hxx;
    endtask
endmodule // mgx_link_master

// [tb/tb.sv]
`timescale 1ns/1ps

module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic xfer_start, xfer_read, xfer_stop, rx_valid, tx_req, tx_valid;
    logic [7:0] rx_data, tx_data, ee_addr, ee_data, cfg_upd_addr, upd_a;
    logic cfg_upd, load_done;
    mgx_pkg::mgx_bytes_t cfg_live;
    logic [7:0] mst [256];
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    int upd_n = 0;
    int load_n = 0;

    initial begin
        forever #2 clk = ~clk;
    end

    // Stored image contents follow the address
    assign ee_data = ee_addr ^ 8'hA5;

    mgx_link_master u_master (.clk(clk), .xfer_start(xfer_start),
        .xfer_read(xfer_read), .xfer_stop(xfer_stop), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_req(tx_req), .tx_valid(tx_valid),
        .tx_data(tx_data));

    mgx_cfg_access u_dut (.clk(clk), .rst_n(rst_n),
        .xfer_start(xfer_start), .xfer_read(xfer_read),
        .xfer_stop(xfer_stop), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_req(tx_req), .tx_valid(tx_valid), .tx_data(tx_data),
        .ee_addr(ee_addr), .ee_data(ee_data), .cfg_live(cfg_live),
        .cfg_upd(cfg_upd), .cfg_upd_addr(cfg_upd_addr),
        .load_done(load_done));

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cfg_upd === 1'b1) begin
            upd_n <= upd_n + 1;
            upd_a <= cfg_upd_addr;
        end
        if (load_done === 1'b1) begin
            load_n <= load_n + 1;
        end
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end

    task automatic test_done();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    function automatic logic [7:0] ref_rd(input logic [7:0] a);
        return (a <= 8'h65) ? mst[a] : 8'h00;
    endfunction

    task automatic send(input logic [7:0] q[$]);
        u_master.bus_start(1'b0);
        foreach (q[i]) u_master.put(q[i]);
        u_master.bus_stop();
        @(posedge clk);
        #1;
    endtask

    task automatic readn(input logic [7:0] a0, input int n, input logic ee);
        logic [7:0] b;
        logic [7:0] a;
        a = a0;
        u_master.bus_start(1'b1);
        for (int i = 0; i < n; i++) begin
            u_master.get(b);
            chk8(b, ee ? (a ^ 8'hA5) : ref_rd(a), "read");
            a = a + 8'h01;
        end
        u_master.bus_stop();
    endtask

    task automatic t_paired();
        int u0;
        u0 = upd_n;
        send('{8'h31, 8'h0F, 8'hAA, 8'hBB});
        mst[8'h0F] = 8'hAA;
        mst[8'h10] = 8'hBB;
        chk8(cfg_live[8'h10], 8'h00, "slave early");
        chk8(8'(upd_n), 8'(u0), "paired upd");
        send('{8'h33, 8'h0E});
        readn(8'h0E, 3, 1'b0);
        send('{8'h35});
        chk8(8'(load_n), 8'h01, "load");
        chk8(cfg_live[8'h0F], 8'hAA, "slave 0f");
        chk8(cfg_live[8'h10], 8'hBB, "slave 10");
        $display("test paired done");
    endtask

    task automatic t_direct();
        int u0;
        u0 = upd_n;
        send('{8'h31, 8'h05, 8'h5A, 8'h3C});
        chk8(cfg_live[8'h05], 8'h5A, "direct");
        chk8(8'(upd_n), 8'(u0 + 2), "upd count");
        chk8(upd_a, 8'h06, "upd addr");
        // Trailing mask byte for 0x07 has no data byte
        send('{8'h32, 8'h05, 8'hF0, 8'h0C, 8'h0F, 8'hA0, 8'hFF});
        chk8(cfg_live[8'h05], (8'h5A & 8'hF0) | (8'h0C & 8'h0F),
            "mask 05");
        chk8(cfg_live[8'h06], (8'h3C & 8'h0F) | (8'hA0 & 8'hF0),
            "mask 06");
        chk8(cfg_live[8'h07], 8'h00, "half pair");
        mst[8'h05] = (8'h5A & 8'hF0) | (8'h0C & 8'h0F);
        mst[8'h06] = (8'h3C & 8'h0F) | (8'hA0 & 8'hF0);
        chk8(8'(load_n), 8'h01, "no load");
        $display("test direct done");
    endtask

    task automatic t_space();
        send('{8'h31, 8'h5F, 8'h11, 8'h22});
        mst[8'h5F] = 8'h11;
        send('{8'h33, 8'h5F});
        readn(8'h5F, 2, 1'b0);
        send('{8'h33, 8'hFF});
        readn(8'hFF, 2, 1'b0);
        // Unknown code: following bytes must not write anything
        send('{8'h40, 8'h05, 8'h00});
        chk8(cfg_live[8'h05], mst[8'h05], "unknown code");
        // Address stands at 0x01 here, so a start at zero is visible
        u_master.bus_start(1'b0);
        u_master.put(8'h34);
        readn(8'h00, 8, 1'b0);
        send('{8'h35, 8'h00});
        chk8(8'(load_n), 8'h01, "void load");
        $display("test space done");
    endtask

    task automatic t_image();
        send('{8'h25, 8'h70});
        readn(8'h70, 3, 1'b1);
        send('{8'h25, 8'h00});
        readn(8'h00, 2, 1'b1);
        $display("test image done");
    endtask

    initial begin
        foreach (mst[i]) mst[i] = 8'h00;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk8(cfg_live[8'h10], 8'h00, "reset live");
        chk8(tx_data, 8'h00, "reset tx");
        t_paired();
        t_direct();
        t_space();
        t_image();
        test_done();
    end
endmodule // tb
